// ===== inc/rcie_pkg.sv
package rcie_pkg;
  // register byte addresses on the apb bus
  localparam logic [7:0] RESET_CAUSE_ADDR = 8'h00;
  localparam logic [7:0] IRQ_CONTROL_ADDR = 8'h04;
  localparam logic [7:0] PERIPH_ENABLE_ADDR = 8'h08;
  localparam logic [7:0] PERIPH_FLAG_ADDR = 8'h0c;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h10;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h14;
  localparam logic [7:0] ENTRY_STATE_ADDR = 8'h18;
  // reset cause field positions
  localparam int STK_OVER_BIT = 7;
  localparam int STK_UNDER_BIT = 6;
  localparam int EXT_PIN_BIT = 3;
  localparam int SOFT_RST_BIT = 2;
  localparam int POWER_ON_BIT = 1;
  localparam int BROWNOUT_BIT = 0;
  localparam logic [7:0] RESET_CAUSE_IMPL = 8'hcf;
  // irq control field positions
  localparam int GLOBAL_EN_BIT = 7;
  localparam int PERIPH_EN_BIT = 6;
  localparam int CORE_SRC_EN_LSB = 3;
  localparam int CORE_SRC_FLAG_LSB = 0;
  localparam int CORE_SRC_COUNT = 3;
  localparam int PERIPH_SRC_COUNT = 8;
  // vector and widths
  localparam int PC_WIDTH = 15;
  localparam logic [14:0] IRQ_VECTOR = 15'h0004;
  localparam int CTX_WIDTH = 8;
  // event status bits
  localparam int EVT_ENTRY_BIT = 0;
  localparam int EVT_RETURN_BIT = 1;
  localparam int EVT_STACK_BIT = 2;
  localparam int EVT_COUNT = 3;
  // reset cause power-on value and bus error read data
  localparam logic [7:0] RESET_CAUSE_RST = 8'h0c;
  localparam logic [31:0] BUS_ERR_DATA = 32'h0000_0000;

  typedef enum logic [1:0] {RCIE_IDLE, RCIE_SAVE, RCIE_VECTOR} rcie_entry_t;
endpackage : rcie_pkg

// ===== logic/rcie_ctx_shadow.sv
`timescale 1ns/1ps
// shadow copies of the critical core context, saved on entry, restored on return
module rcie_ctx_shadow (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  // control
  input wire logic saveStb,
  // live core context
  input wire logic [rcie_pkg::CTX_WIDTH-1:0] workIn,
  input wire logic [rcie_pkg::CTX_WIDTH-1:0] statusIn,
  input wire logic [rcie_pkg::CTX_WIDTH-1:0] bankIn,
  input wire logic [rcie_pkg::CTX_WIDTH-1:0] indLoIn,
  input wire logic [rcie_pkg::CTX_WIDTH-1:0] indHiIn,
  input wire logic [rcie_pkg::CTX_WIDTH-1:0] pcHighIn,
  // stored copies
  output logic [6*rcie_pkg::CTX_WIDTH-1:0] shadowOut
);
  logic [6*rcie_pkg::CTX_WIDTH-1:0] shadow_reg;
  logic [6*rcie_pkg::CTX_WIDTH-1:0] shadow_next;

  // timeout and power-down bits (status 4,3) are not shadowed: they keep reset meaning
  always_comb begin
    shadow_next = shadow_reg;
    if (saveStb) begin
      shadow_next = {pcHighIn, indHiIn, indLoIn, bankIn, statusIn & 8'he7, workIn};
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shadow_reg <= '0;
    end else if (clkEn) begin
      shadow_reg <= shadow_next;
    end
  end

  assign shadowOut = shadow_reg;
endmodule : rcie_ctx_shadow

// ===== logic/rcie_top.sv
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - stack overflow flag set by hardware, held until firmware writes zero or a power-on reset.
// - stack underflow flag set by hardware, held until firmware writes zero or a power-on reset.
// - external pin flag active low, cleared on pin reset, firmware may set.
// - soft reset flag active low, cleared by reset instruction, firmware may set.
// - power-on bit cleared on power-on reset; firmware writes one afterwards.
// - brown-out bit cleared on power-on or brown-out reset; firmware sets it.
// - reset cause is 8 bits; bits 5 and 4 read zero.
// - any device reset clears global enable, blocking all vectoring.
// - take interrupt only with global, own and, for peripherals, peripheral enable.
// - source flags set on event regardless of any enable.
// - entry flushes prefetch, clears global enable, pushes pc, shadows context.
// - after entry actions the pc loads the fixed vector.
// - with global enable clear events only flag; pending taken once re-enabled.
// - return pops address, restores shadow context, sets global enable.
// - shadow covers work, status less timeout/power-down, bank, indirect, pc high.
// - global enable set enables active interrupts; clear disables all.
module rcie_top (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  // reset cause events; stack events sampled always, the others only in the first enabled cycle after rst release
  input wire logic powerOnEvt,
  input wire logic brownoutEvt,
  input wire logic extPinEvt,
  input wire logic softResetEvt,
  input wire logic stackOverEvt,
  input wire logic stackUnderEvt,
  // interrupt sources, one-cycle pulses
  input wire logic [rcie_pkg::CORE_SRC_COUNT-1:0] coreSrcEvt,
  input wire logic [rcie_pkg::PERIPH_SRC_COUNT-1:0] periphSrcEvt,
  // core handshake
  input wire logic retfieExec,
  input wire logic [rcie_pkg::PC_WIDTH-1:0] curPc,
  input wire logic [rcie_pkg::CTX_WIDTH-1:0] workIn,
  input wire logic [rcie_pkg::CTX_WIDTH-1:0] statusIn,
  input wire logic [rcie_pkg::CTX_WIDTH-1:0] bankIn,
  input wire logic [rcie_pkg::CTX_WIDTH-1:0] indLoIn,
  input wire logic [rcie_pkg::CTX_WIDTH-1:0] indHiIn,
  input wire logic [rcie_pkg::CTX_WIDTH-1:0] pcHighIn,
  // core controls
  output logic flushPrefetch,
  output logic pushPc,
  output logic [rcie_pkg::PC_WIDTH-1:0] pushPcValue,
  output logic loadVector,
  output logic [rcie_pkg::PC_WIDTH-1:0] vectorPc,
  output logic restoreCtx,
  output logic [6*rcie_pkg::CTX_WIDTH-1:0] shadowCtx,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq
);
  logic [7:0] cause_reg, cause_next;
  logic [7:0] irqCtl_reg, irqCtl_next;
  logic [7:0] perEn_reg, perEn_next;
  logic [7:0] perFlag_reg, perFlag_next;
  logic [2:0] evtSts_reg, evtSts_next;
  logic [2:0] evtMask_reg, evtMask_next;
  rcie_pkg::rcie_entry_t state_reg, state_next;
  logic [rcie_pkg::PC_WIDTH-1:0] savedPc_reg, savedPc_next;
  logic flush_reg, flush_next, push_reg, push_next, vec_reg, vec_next, rest_reg, rest_next;
  logic [31:0] rdata_reg, rdata_next;
  logic ready_reg, ready_next, err_reg, err_next, irq_reg, irq_next;
  logic [6*rcie_pkg::CTX_WIDTH-1:0] shadowQ;
  logic strapDone_reg;
  logic [rcie_pkg::PC_WIDTH-1:0] vecPc_reg;
  logic wrEn, rdEn, addrOk, saveStb;
  logic [rcie_pkg::CORE_SRC_COUNT-1:0] coreHit;
  logic [rcie_pkg::PERIPH_SRC_COUNT-1:0] perHit;
  logic takeIrq;

  // apb access phase; answer with one wait state
  assign wrEn = psel && penable && pwrite && !ready_reg;
  assign rdEn = psel && penable && !pwrite && !ready_reg;
  assign addrOk = (paddr == rcie_pkg::RESET_CAUSE_ADDR) || (paddr == rcie_pkg::IRQ_CONTROL_ADDR) ||
                  (paddr == rcie_pkg::PERIPH_ENABLE_ADDR) || (paddr == rcie_pkg::PERIPH_FLAG_ADDR) ||
                  (paddr == rcie_pkg::IRQ_STATUS_ADDR) || (paddr == rcie_pkg::IRQ_MASK_ADDR) ||
                  (paddr == rcie_pkg::ENTRY_STATE_ADDR);

  // per-source pending, gated by own enable; peripherals also need the peripheral enable
  genvar gi;
  generate
    for (gi = 0; gi < rcie_pkg::CORE_SRC_COUNT; gi++) begin : g_core
      assign coreHit[gi] = irqCtl_reg[rcie_pkg::CORE_SRC_EN_LSB+gi] &&
                           irqCtl_reg[rcie_pkg::CORE_SRC_FLAG_LSB+gi];
    end
    for (gi = 0; gi < rcie_pkg::PERIPH_SRC_COUNT; gi++) begin : g_per
      assign perHit[gi] = perEn_reg[gi] && perFlag_reg[gi] &&
                          irqCtl_reg[rcie_pkg::PERIPH_EN_BIT];
    end
  endgenerate

  // a pending flag left set is taken again as soon as the global enable returns
  assign takeIrq = (state_reg == rcie_pkg::RCIE_IDLE) && irqCtl_reg[rcie_pkg::GLOBAL_EN_BIT] &&
                   ((|coreHit) || (|perHit)) && !retfieExec;
  assign saveStb = clkEn && takeIrq;

  // reset cause register; hardware updates are applied after the firmware write so they win
  always_comb begin
    cause_next = cause_reg;
    if (wrEn && paddr == rcie_pkg::RESET_CAUSE_ADDR) begin
      cause_next = pwdata[7:0] & rcie_pkg::RESET_CAUSE_IMPL;
    end
    if (stackOverEvt) cause_next[rcie_pkg::STK_OVER_BIT] = 1'b1;
    if (stackUnderEvt) cause_next[rcie_pkg::STK_UNDER_BIT] = 1'b1;
    if (!strapDone_reg) begin
      if (extPinEvt) cause_next[rcie_pkg::EXT_PIN_BIT] = 1'b0;
      if (softResetEvt) cause_next[rcie_pkg::SOFT_RST_BIT] = 1'b0;
      // power-on starts from a clean cause word: stack flags low, pin and instruction flags high
      if (powerOnEvt) begin
        cause_next = rcie_pkg::RESET_CAUSE_RST;
      end
      if (powerOnEvt || brownoutEvt) cause_next[rcie_pkg::BROWNOUT_BIT] = 1'b0;
    end
  end

  // interrupt control, peripheral enable and flags
  always_comb begin
    irqCtl_next = irqCtl_reg;
    perEn_next = perEn_reg;
    perFlag_next = perFlag_reg;
    if (wrEn && paddr == rcie_pkg::IRQ_CONTROL_ADDR) irqCtl_next = pwdata[7:0];
    if (wrEn && paddr == rcie_pkg::PERIPH_ENABLE_ADDR) perEn_next = pwdata[7:0];
    if (wrEn && paddr == rcie_pkg::PERIPH_FLAG_ADDR) perFlag_next = pwdata[7:0];
    // flags set whatever the enables; set beats a same-cycle clear
    irqCtl_next[rcie_pkg::CORE_SRC_FLAG_LSB +: rcie_pkg::CORE_SRC_COUNT] =
      irqCtl_next[rcie_pkg::CORE_SRC_FLAG_LSB +: rcie_pkg::CORE_SRC_COUNT] | coreSrcEvt;
    perFlag_next = perFlag_next | periphSrcEvt;
    if (takeIrq) irqCtl_next[rcie_pkg::GLOBAL_EN_BIT] = 1'b0;
    if (retfieExec && state_reg == rcie_pkg::RCIE_IDLE) irqCtl_next[rcie_pkg::GLOBAL_EN_BIT] = 1'b1;
  end

  // entry sequencer: save, then vector, never interruptible in between
  always_comb begin
    state_next = state_reg;
    savedPc_next = savedPc_reg;
    flush_next = 1'b0;
    push_next = 1'b0;
    vec_next = 1'b0;
    rest_next = 1'b0;
    case (state_reg)
      rcie_pkg::RCIE_IDLE: begin
        if (takeIrq) begin
          flush_next = 1'b1;
          savedPc_next = curPc;
          state_next = rcie_pkg::RCIE_SAVE;
        end else if (retfieExec) begin
          rest_next = 1'b1;
        end
      end
      rcie_pkg::RCIE_SAVE: begin
        push_next = 1'b1;
        state_next = rcie_pkg::RCIE_VECTOR;
      end
      rcie_pkg::RCIE_VECTOR: begin
        vec_next = 1'b1;
        state_next = rcie_pkg::RCIE_IDLE;
      end
      default: state_next = rcie_pkg::RCIE_IDLE;
    endcase
  end

  // event status (clear on read, set wins) and mask
  always_comb begin
    evtSts_next = evtSts_reg;
    evtMask_next = evtMask_reg;
    if (rdEn && paddr == rcie_pkg::IRQ_STATUS_ADDR) evtSts_next = '0;
    if (wrEn && paddr == rcie_pkg::IRQ_MASK_ADDR) evtMask_next = pwdata[rcie_pkg::EVT_COUNT-1:0];
    if (vec_next) evtSts_next[rcie_pkg::EVT_ENTRY_BIT] = 1'b1;
    if (rest_next) evtSts_next[rcie_pkg::EVT_RETURN_BIT] = 1'b1;
    if (stackOverEvt || stackUnderEvt) evtSts_next[rcie_pkg::EVT_STACK_BIT] = 1'b1;
    irq_next = |(evtSts_next & evtMask_next);
  end

  // apb read mux and answer
  always_comb begin
    rdata_next = rcie_pkg::BUS_ERR_DATA;
    ready_next = psel && penable && !ready_reg;
    err_next = psel && penable && !ready_reg && !addrOk;
    if (rdEn) begin
      case (paddr)
        rcie_pkg::RESET_CAUSE_ADDR: rdata_next = {24'h000000, cause_reg & rcie_pkg::RESET_CAUSE_IMPL};
        rcie_pkg::IRQ_CONTROL_ADDR: rdata_next = {24'h000000, irqCtl_reg};
        rcie_pkg::PERIPH_ENABLE_ADDR: rdata_next = {24'h000000, perEn_reg};
        rcie_pkg::PERIPH_FLAG_ADDR: rdata_next = {24'h000000, perFlag_reg};
        rcie_pkg::IRQ_STATUS_ADDR: rdata_next = {29'h0000000, evtSts_reg};
        rcie_pkg::IRQ_MASK_ADDR: rdata_next = {29'h0000000, evtMask_reg};
        rcie_pkg::ENTRY_STATE_ADDR: rdata_next = {15'h0000, savedPc_reg, 2'h0};
        default: rdata_next = rcie_pkg::BUS_ERR_DATA;
      endcase
    end
  end

  // any device reset leaves the global enable clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irqCtl_reg <= 8'h00;
      vecPc_reg <= rcie_pkg::IRQ_VECTOR;
      perEn_reg <= 8'h00;
      perFlag_reg <= 8'h00;
      evtSts_reg <= 3'h0;
      evtMask_reg <= 3'h0;
      state_reg <= rcie_pkg::RCIE_IDLE;
      savedPc_reg <= 15'h0000;
      flush_reg <= 1'b0;
      push_reg <= 1'b0;
      vec_reg <= 1'b0;
      rest_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      ready_reg <= 1'b0;
      err_reg <= 1'b0;
      irq_reg <= 1'b0;
      strapDone_reg <= 1'b0;
    end else if (clkEn) begin
      irqCtl_reg <= irqCtl_next;
      perEn_reg <= perEn_next;
      perFlag_reg <= perFlag_next;
      evtSts_reg <= evtSts_next;
      evtMask_reg <= evtMask_next;
      state_reg <= state_next;
      savedPc_reg <= savedPc_next;
      flush_reg <= flush_next;
      push_reg <= push_next;
      vec_reg <= vec_next;
      rest_reg <= rest_next;
      rdata_reg <= rdata_next;
      ready_reg <= ready_next;
      err_reg <= err_next;
      irq_reg <= irq_next;
      strapDone_reg <= 1'b1; // reset causes caught once, in the first enabled cycle
    end
  end

  // cause flags must outlive the device reset they record, so no reset here;
  // the power-on event gives the word its first defined value
  always_ff @(posedge core_clk) begin
    if (clkEn && !rst) begin
      cause_reg <= cause_next;
    end
  end

  // context shadow copies
  rcie_ctx_shadow u_shadow (
    .core_clk(core_clk),
    .rst(rst),
    .clkEn(clkEn),
    .saveStb(saveStb),
    .workIn(workIn),
    .statusIn(statusIn),
    .bankIn(bankIn),
    .indLoIn(indLoIn),
    .indHiIn(indHiIn),
    .pcHighIn(pcHighIn),
    .shadowOut(shadowQ)
  );

  assign flushPrefetch = flush_reg;
  assign pushPc = push_reg;
  assign pushPcValue = savedPc_reg;
  assign loadVector = vec_reg;
  assign vectorPc = vecPc_reg; // fixed vector, held in a flop
  assign restoreCtx = rest_reg;
  assign shadowCtx = shadowQ;
  assign prdata = rdata_reg;
  assign pready = ready_reg;
  assign pslverr = err_reg;
  assign irq = irq_reg;
endmodule : rcie_top

// ===== dv/rcie_core_model.sv
`timescale 1ns/1ps
// behavioural core: free-running pc, one-deep return stack, context lanes from pc
module rcie_core_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // controls from the entry unit
  input wire logic pushPc,
  input wire logic [14:0] pushPcValue,
  input wire logic loadVector,
  input wire logic [14:0] vectorPc,
  input wire logic restoreCtx,
  // live core state
  output logic [14:0] curPc,
  output logic [7:0] workIn,
  output logic [7:0] statusIn
);
  logic [14:0] retAddr;
  // pc moves every cycle so a late sample of it shows up as a wrong push
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      curPc <= 15'h0000;
      retAddr <= 15'h0000;
    end else begin
      if (pushPc) retAddr <= pushPcValue;
      if (loadVector) curPc <= vectorPc;
      else if (restoreCtx) curPc <= retAddr; // pop on return
      else curPc <= curPc + 15'h0001;
    end
  end
  // context follows pc so shadow copies can be traced to their sample cycle
  assign workIn = curPc[7:0];
  assign statusIn = ~curPc[7:0];
endmodule : rcie_core_model

// ===== dv/rcie_top_props.sv
`timescale 1ns/1ps
// temporal checks on the entry and return sequence
module rcie_top_props (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // core side
  input wire logic flushPrefetch,
  input wire logic pushPc,
  input wire logic [rcie_pkg::PC_WIDTH-1:0] pushPcValue,
  input wire logic loadVector,
  input wire logic [rcie_pkg::PC_WIDTH-1:0] vectorPc,
  input wire logic restoreCtx,
  input wire logic [6*rcie_pkg::CTX_WIDTH-1:0] shadowCtx,
  input wire logic retfieExec,
  input wire logic [rcie_pkg::PC_WIDTH-1:0] curPc,
  input wire logic [rcie_pkg::CTX_WIDTH-1:0] workIn,
  // apb
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // entry steps in fixed order
  AST_FLUSH_PUSH: assert property (flushPrefetch |=> pushPc) else $error("push late");
  AST_PUSH_VEC: assert property (pushPc |=> loadVector && vectorPc == 15'h0004) else $error("bad vector");
  AST_VEC_CONST: assert property (vectorPc == 15'h0004) else $error("vector moved");
  AST_ATOMIC: assert property (flushPrefetch |=> (!flushPrefetch && !restoreCtx) [*2])
    else $error("entry interrupted");
  AST_RET: assert property (restoreCtx |-> $past(retfieExec)) else $error("stray restore");
  // pc and context sampled on the take cycle
  AST_PUSH_VALUE: assert property (pushPc |-> pushPcValue == $past(curPc, 2)) else $error("bad pc");
  AST_SHADOW_WORK: assert property (pushPc |-> shadowCtx[7:0] == $past(workIn, 2)) else $error("bad work");
  AST_SHADOW_STATUS: assert property (pushPc |-> shadowCtx[12:11] == 2'b00) else $error("bits kept");
  AST_RSV_ZERO: assert property (pready && !pwrite && paddr == 8'h00 |-> prdata[5:4] == 2'b00)
    else $error("reserved set");
  // main scenarios
  COV_ENTRY: cover property (loadVector);
  COV_RETURN: cover property (restoreCtx);
  COV_CAUSE_READ: cover property (pready && !pwrite && paddr == 8'h00);
endmodule : rcie_top_props

bind rcie_top rcie_top_props chkProps (.core_clk(core_clk), .rst(rst), .flushPrefetch(flushPrefetch),
  .pushPc(pushPc), .pushPcValue(pushPcValue), .loadVector(loadVector), .vectorPc(vectorPc),
  .restoreCtx(restoreCtx), .shadowCtx(shadowCtx), .retfieExec(retfieExec), .curPc(curPc),
  .workIn(workIn), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready));

// ===== dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // stimulus and observed signals
  logic core_clk = 1'b0, rst = 1'b1, powerOnEvt = 1'b0, brownoutEvt = 1'b0, extPinEvt = 1'b0;
  logic softResetEvt = 1'b0, stackOverEvt = 1'b0, stackUnderEvt = 1'b0, retfieExec = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq, err;
  logic clkEn = 1'b1;
  logic flushPrefetch, pushPc, loadVector, restoreCtx;
  logic [2:0] coreSrcEvt = 3'h0;
  logic [7:0] periphSrcEvt = 8'h00, paddr = 8'h00, rnd = 8'h25, workIn, statusIn;
  logic [14:0] curPc, pushPcValue, vectorPc;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [47:0] shadowCtx;
  int badCount = 0, checked = 0, hits;
  always #5 core_clk = ~core_clk;
  rcie_top uut (.core_clk(core_clk), .rst(rst), .clkEn(clkEn), .powerOnEvt(powerOnEvt),
    .brownoutEvt(brownoutEvt), .extPinEvt(extPinEvt), .softResetEvt(softResetEvt),
    .stackOverEvt(stackOverEvt), .stackUnderEvt(stackUnderEvt), .coreSrcEvt(coreSrcEvt),
    .periphSrcEvt(periphSrcEvt), .retfieExec(retfieExec), .curPc(curPc), .workIn(workIn),
    .statusIn(statusIn), .bankIn(8'h1f), .indLoIn(8'h3c), .indHiIn(8'h20), .pcHighIn({1'b0, curPc[14:8]}),
    .flushPrefetch(flushPrefetch), .pushPc(pushPc), .pushPcValue(pushPcValue), .loadVector(loadVector),
    .vectorPc(vectorPc), .restoreCtx(restoreCtx), .shadowCtx(shadowCtx), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq));
  rcie_core_model coreModel (.core_clk(core_clk), .rst(rst), .pushPc(pushPc), .pushPcValue(pushPcValue),
    .loadVector(loadVector), .vectorPc(vectorPc), .restoreCtx(restoreCtx), .curPc(curPc),
    .workIn(workIn), .statusIn(statusIn));
  // lfsr step for repeatable random picks
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // cause after reset from a firmware-set 0x0f: only the bits of the reset taken go low, power-on also clearing the brown-out bit
  function automatic logic [31:0] expCause(input logic [3:0] ev);
    return {28'h0, ~ev[1], ~ev[0], ~ev[3], ~(ev[3] | ev[2])};
  endfunction : expCause
  task automatic wrapUp();
    if (badCount == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrapUp
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic bound(input int n);
    if (n >= 20) begin
      badCount++;
      wrapUp();
    end
  endtask : bound
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    bound(n);
  endtask : apb
  // one-cycle event pulse: 0 over, 1 under, 2 return, 3 core, 4 peripheral
  task automatic pulse(input int s, input logic [7:0] v);
    @(posedge core_clk);
    {stackOverEvt, stackUnderEvt, retfieExec} <= {s == 0, s == 1, s == 2};
    coreSrcEvt <= (s == 3) ? v[2:0] : 3'h0;
    periphSrcEvt <= (s == 4) ? v : 8'h00;
    @(posedge core_clk);
    {stackOverEvt, stackUnderEvt, retfieExec, coreSrcEvt, periphSrcEvt} <= 14'h0;
  endtask : pulse
  // bounded wait on 0 flush, 1 vector load, 2 restore
  task automatic waitSig(input int s);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while ((s == 0 ? flushPrefetch : s == 1 ? loadVector : restoreCtx) !== 1'b1 && n < 20);
    bound(n);
  endtask : waitSig
  task automatic noEntry();
    hits = 0;
    repeat (10) begin
      @(posedge core_clk);
      if (flushPrefetch !== 1'b0) hits++;
    end
  endtask : noEntry
  task automatic doReset(input logic [3:0] ev);
    @(posedge core_clk);
    rst <= 1'b1;
    {powerOnEvt, brownoutEvt, extPinEvt, softResetEvt} <= ev;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    {powerOnEvt, brownoutEvt, extPinEvt, softResetEvt} <= 4'h0;
  endtask : doReset
  // main sequence
  initial begin
    for (int i = 0; i < 4; i++) begin
      doReset(4'h8 >> i);
      apb(1'b0, rcie_pkg::RESET_CAUSE_ADDR, 32'h0);
      chk(rd, expCause(4'h8 >> i));
      apb(1'b0, rcie_pkg::IRQ_CONTROL_ADDR, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, rcie_pkg::RESET_CAUSE_ADDR, 32'h0f);
    end
    apb(1'b1, rcie_pkg::RESET_CAUSE_ADDR, 32'h3f);
    apb(1'b0, rcie_pkg::RESET_CAUSE_ADDR, 32'h0);
    chk(rd, 32'h0f);
    pulse(0, 8'h0);
    apb(1'b0, rcie_pkg::RESET_CAUSE_ADDR, 32'h0);
    chk(rd, 32'h8f);
    pulse(1, 8'h0);
    apb(1'b0, rcie_pkg::RESET_CAUSE_ADDR, 32'h0);
    chk(rd, 32'hcf);
    // stack flags survive a later instruction reset
    doReset(4'h1);
    apb(1'b0, rcie_pkg::RESET_CAUSE_ADDR, 32'h0);
    chk(rd, 32'hcb);
    apb(1'b1, rcie_pkg::RESET_CAUSE_ADDR, 32'h0f);
    apb(1'b0, rcie_pkg::RESET_CAUSE_ADDR, 32'h0);
    chk(rd, 32'h0f);
    pulse(1, 8'h0);
    // flag while globally disabled, then enable and take it
    apb(1'b1, rcie_pkg::IRQ_CONTROL_ADDR, 32'h08);
    pulse(3, 8'h01);
    noEntry();
    chk(hits, 0);
    apb(1'b0, rcie_pkg::IRQ_CONTROL_ADDR, 32'h0);
    chk(rd, 32'h09);
    apb(1'b1, rcie_pkg::IRQ_CONTROL_ADDR, 32'h89);
    waitSig(0);
    waitSig(1);
    chk(vectorPc, rcie_pkg::IRQ_VECTOR);
    apb(1'b0, rcie_pkg::IRQ_CONTROL_ADDR, 32'h0);
    chk(rd, 32'h09);
    // interrupt output: masked, raised, cleared by status read
    chk(irq, 1'b0);
    apb(1'b1, rcie_pkg::IRQ_MASK_ADDR, 32'h1);
    repeat (2) @(posedge core_clk);
    chk(irq, 1'b1);
    apb(1'b0, rcie_pkg::IRQ_STATUS_ADDR, 32'h0);
    chk(rd, 32'h5);
    repeat (2) @(posedge core_clk);
    chk(irq, 1'b0);
    // firmware clears the flag, then returns
    apb(1'b1, rcie_pkg::IRQ_CONTROL_ADDR, 32'h08);
    pulse(2, 8'h0);
    waitSig(2);
    noEntry();
    chk(hits, 0);
    apb(1'b0, rcie_pkg::IRQ_CONTROL_ADDR, 32'h0);
    chk(rd, 32'h88);
    // peripheral source needs the peripheral enable too
    rnd = lfsr(rnd);
    apb(1'b1, rcie_pkg::PERIPH_ENABLE_ADDR, 32'h1 << rnd[2:0]);
    pulse(4, 8'h1 << rnd[2:0]);
    noEntry();
    chk(hits, 0);
    // frozen clock enable drops events and holds every flag
    clkEn <= 1'b0;
    pulse(4, 8'hff);
    clkEn <= 1'b1;
    apb(1'b0, rcie_pkg::PERIPH_FLAG_ADDR, 32'h0);
    chk(rd, 32'h1 << rnd[2:0]);
    apb(1'b1, rcie_pkg::IRQ_CONTROL_ADDR, 32'hc8);
    waitSig(0);
    // random enable patterns read back unchanged
    repeat (4) begin
      rnd = lfsr(rnd);
      apb(1'b1, rcie_pkg::PERIPH_ENABLE_ADDR, {24'h0, rnd});
      apb(1'b0, rcie_pkg::PERIPH_ENABLE_ADDR, 32'h0);
      chk(rd, {24'h0, rnd});
    end
    // unmapped address is refused
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    wrapUp();
  end
endmodule : tb_top
